// [src/atapw_core.sv]
/*
 * Device-side task-file logic for PIO sector writes (28-bit, 48-bit,
 * write-verify alias, and single-sector security commands) with reset and
 * BSY/DRQ/interrupt sequencing.
 * Assumes host bus pins are asynchronous and are synchronised here, and
 * that a media engine drains each full sector from the buffer.
 */
// Summary of operation
// - Command 34h takes write sectors from the host, then records them.
// - Sector data crosses the data register as 16-bit words, one per access.
// - An uncorrectable media error ends the write at the failing sector.
// - Extended count: current byte is bits 7-0, previous byte bits 15-8.
// - Extended count of zero means 65,536 sectors.
// - 48-bit address: current bytes give 23-0, previous bytes give 47-24.
// - After an error, address registers hold the first failing address.
// - Command 3Ch runs exactly as 30h, with no read-back verify.
// - BSY rises within 400 ns of any command code write; unsupported codes abort at once without setting BSY.
// - Power-on or bus reset: BSY within 400 ns, ready within 31 s.
// - Software reset: BSY within 400 ns, ready within 31 s of release.
// - Data-in: clear BSY, set DRQ and interrupt within 30 s.
// - Data-in: BSY again within 10 us of the 256th data read.
// - Data-out: clear BSY and set DRQ within 700 us.
// - Data-out: BSY within 5 us of the 256th data write.
// - Data-out block taken: BSY=0, RDY=1, interrupt within 30 s.
// - Standby power-up, first security command: data-request limit 10 s.
// - 28-bit write: count zero means 256 sectors; retry bit ignored.
`timescale 1ns/1ns
`default_nettype none
module atapw_core #(
	parameter logic [31:0] DRQ_TO = atapw_pkg::DRQ_TO_CYC,
	parameter logic [31:0] SEC_TO = atapw_pkg::SEC_TO_CYC,
	parameter logic [31:0] MED_TO = atapw_pkg::MED_TO_CYC,
	parameter logic [31:0] RDY_WAIT = atapw_pkg::RDY_CYC,
	parameter logic DEV_SEL = 1'b0
) (
	// Clock and power-on reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Host task-file bus pins.
	input wire logic hst_reset_n,
	input wire logic hst_cs0_n,
	input wire logic hst_cs1_n,
	input wire logic [2:0] hst_addr,
	input wire logic hst_wr_n,
	input wire logic hst_rd_n,
	input wire logic [15:0] hst_dd_in,
	output logic [15:0] hst_dd_out,
	output logic hst_dd_oe,
	output logic hst_intrq,
	// Power-up mode strap.
	input wire logic pwr_standby,
	// Media engine side.
	input wire logic med_spun,
	output logic med_req,
	output atapw_pkg::atapw_med_t med_cmd,
	input wire logic [7:0] med_raddr,
	output logic [15:0] med_rdata,
	input wire logic med_done,
	input wire logic med_err
);
	localparam int SW = 25;

	logic [SW-1:0] pin_s1;
	logic [SW-1:0] pin_s2;
	logic rst_s, cs0_s, cs1_s, wr_s, rd_s, stby_s;
	logic [2:0] addr_s;
	logic [15:0] dd_s;
	logic wr_q, rd_q;
	logic wr_pulse, rd_end, cmd_sel, ctl_sel, srst_act;
	logic cmd_wr, data_wr, status_rd, dev_wr;
	logic [15:0] feat, cnt, low, mid, high;
	logic [7:0] dev;
	logic hob, srst, nien;
	atapw_pkg::atapw_state_t state;
	atapw_pkg::atapw_kind_t kind;
	logic bsy, rdy, drq, errb, intrq_pend;
	logic [7:0] err_reg;
	logic [16:0] remaining;
	logic [47:0] cur_lba;
	logic [7:0] widx;
	logic ext, armed;
	logic tmr_load, tmr_exp;
	logic [31:0] tmr_val;
	logic rep_en;
	logic [47:0] rep_lba;
	logic [16:0] rep_cnt;
	logic standby, first_cmd;
	logic [7:0] status;

	// Sort a command code into the kinds this block executes.
	function automatic atapw_pkg::atapw_kind_t cmd_kind(input logic [7:0] c);
		if (c[7:1] == atapw_pkg::C_WR28[7:1] || c == atapw_pkg::C_WVFY) begin
			cmd_kind = atapw_pkg::K_W28;
		end else if (c == atapw_pkg::C_WREXT) begin
			cmd_kind = atapw_pkg::K_WEXT;
		end else if (c == atapw_pkg::C_SSETPW || c == atapw_pkg::C_SUNLK ||
				c == atapw_pkg::C_SERASE || c == atapw_pkg::C_SDISPW) begin
			cmd_kind = atapw_pkg::K_SEC;
		end else begin
			cmd_kind = atapw_pkg::K_NONE;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and strobe edges.

	// Two flip-flops on every host pin and the strap before use.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1 <= {SW{1'b1}};
			pin_s2 <= {SW{1'b1}};
		end else begin
			pin_s1 <= {hst_reset_n, hst_cs0_n, hst_cs1_n, hst_addr, hst_wr_n,
				hst_rd_n, hst_dd_in, pwr_standby};
			pin_s2 <= pin_s1;
		end
	end

	// Unpack the synchronised pins.
	assign {rst_s, cs0_s, cs1_s, addr_s, wr_s, rd_s, dd_s, stby_s} = pin_s2;

	// Delayed strobes for edge detection.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= 1'b1;
			rd_q <= 1'b1;
		end else begin
			wr_q <= wr_s;
			rd_q <= rd_s;
		end
	end

	// Accesses complete on the rising edge of the strobe.
	assign wr_pulse = wr_s & ~wr_q;
	assign rd_end = rd_s & ~rd_q;
	assign cmd_sel = ~cs0_s & cs1_s;
	assign ctl_sel = cs0_s & ~cs1_s & (addr_s == atapw_pkg::A_DEVCTL);
	assign srst_act = srst | ~rst_s;
	assign cmd_wr = wr_pulse & cmd_sel & (addr_s == atapw_pkg::A_CMD) &
		(dev[atapw_pkg::DV_SEL] == DEV_SEL) & ~bsy & ~srst_act;
	assign data_wr = wr_pulse & cmd_sel & (addr_s == atapw_pkg::A_DATA) &
		drq & (state == atapw_pkg::S_XFER);
	assign status_rd = rd_end & cmd_sel & (addr_s == atapw_pkg::A_CMD);
	assign dev_wr = wr_pulse & cmd_sel & (addr_s == atapw_pkg::A_DEV);
	assign kind = cmd_kind(dd_s[7:0]);

	////////////////////////////////////////////////////////////////////////
	// Task-file registers.

	// Byte registers keep current and previous values; results are loaded
	// back when a command ends.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			feat <= 16'h0000;
			cnt <= 16'h0000;
			low <= 16'h0000;
			mid <= 16'h0000;
			high <= 16'h0000;
			dev <= 8'h00;
		end else if (rep_en) begin
			cnt <= rep_cnt[15:0];
			if (ext) begin
				low <= {rep_lba[31:24], rep_lba[7:0]};
				mid <= {rep_lba[39:32], rep_lba[15:8]};
				high <= {rep_lba[47:40], rep_lba[23:16]};
			end else begin
				low[7:0] <= rep_lba[7:0];
				mid[7:0] <= rep_lba[15:8];
				high[7:0] <= rep_lba[23:16];
				dev[3:0] <= rep_lba[27:24];
			end
		end else if (wr_pulse && cmd_sel && !bsy) begin
			case (addr_s)
				atapw_pkg::A_FEAT: feat <= {feat[7:0], dd_s[7:0]};
				atapw_pkg::A_COUNT: cnt <= {cnt[7:0], dd_s[7:0]};
				atapw_pkg::A_LOW: low <= {low[7:0], dd_s[7:0]};
				atapw_pkg::A_MID: mid <= {mid[7:0], dd_s[7:0]};
				atapw_pkg::A_HIGH: high <= {high[7:0], dd_s[7:0]};
				atapw_pkg::A_DEV: dev <= dd_s[7:0];
				default: ;
			endcase
		end
	end

	// Device control: soft reset, interrupt disable and high-order select.
	// Any command block write drops the high-order select.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hob <= 1'b0;
			srst <= 1'b0;
			nien <= 1'b0;
		end else if (wr_pulse && ctl_sel) begin
			hob <= dd_s[atapw_pkg::DC_HOB];
			srst <= dd_s[atapw_pkg::DC_SRST];
			nien <= dd_s[atapw_pkg::DC_NIEN];
		end else if ((wr_pulse && cmd_sel) || dev_wr) begin
			hob <= 1'b0;
		end
	end

	// Follow the synchronised strap until the first command is taken.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			standby <= 1'b0;
			first_cmd <= 1'b1;
		end else begin
			if (first_cmd) begin
				standby <= stby_s;
			end
			if (cmd_wr) begin
				first_cmd <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command engine.

	// Reset handling, command setup, data phase and media completion.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= atapw_pkg::S_RESET;
			bsy <= 1'b1;
			rdy <= 1'b0;
			drq <= 1'b0;
			errb <= 1'b0;
			err_reg <= 8'h00;
			intrq_pend <= 1'b0;
			remaining <= 17'h00000;
			cur_lba <= 48'h0;
			widx <= 8'h00;
			ext <= 1'b0;
			armed <= 1'b0;
			tmr_load <= 1'b0;
			tmr_val <= 32'h0;
			rep_en <= 1'b0;
			rep_lba <= 48'h0;
			rep_cnt <= 17'h00000;
			med_req <= 1'b0;
			med_cmd <= '0;
		end else begin
			tmr_load <= 1'b0;
			rep_en <= 1'b0;
			med_req <= 1'b0;
			if (status_rd) begin
				intrq_pend <= 1'b0;
			end
			if (srst_act) begin
				state <= atapw_pkg::S_RESET;
				bsy <= 1'b1;
				rdy <= 1'b0;
				drq <= 1'b0;
				intrq_pend <= 1'b0;
				armed <= 1'b0;
			end else begin
				case (state)
					atapw_pkg::S_RESET: begin
						if (!armed) begin
							armed <= 1'b1;
							tmr_load <= 1'b1;
							tmr_val <= RDY_WAIT;
						end else if (tmr_exp) begin
							bsy <= 1'b0;
							rdy <= 1'b1;
							errb <= 1'b0;
							err_reg <= 8'h00;
							state <= atapw_pkg::S_IDLE;
						end
					end
					atapw_pkg::S_IDLE: begin
						if (cmd_wr) begin
							bsy <= 1'b1;
							errb <= 1'b0;
							err_reg <= 8'h00;
							widx <= 8'h00;
							ext <= (kind == atapw_pkg::K_WEXT);
							med_cmd.code <= dd_s[7:0];
							med_cmd.security <= (kind == atapw_pkg::K_SEC);
							tmr_load <= 1'b1;
							if (standby && first_cmd && kind == atapw_pkg::K_SEC) begin
								tmr_val <= SEC_TO;
							end else begin
								tmr_val <= DRQ_TO;
							end
							state <= atapw_pkg::S_WAIT;
							case (kind)
								atapw_pkg::K_WEXT: begin
									cur_lba <= {high[15:8], mid[15:8], low[15:8],
										high[7:0], mid[7:0], low[7:0]};
									remaining <= (cnt == 16'h0000) ?
										atapw_pkg::CNTEXT_ZERO : {1'b0, cnt};
								end
								atapw_pkg::K_W28: begin
									cur_lba <= {20'h00000, dev[3:0], high[7:0],
										mid[7:0], low[7:0]};
									remaining <= (cnt[7:0] == 8'h00) ?
										atapw_pkg::CNT28_ZERO : {9'h000, cnt[7:0]};
								end
								atapw_pkg::K_SEC: begin
									cur_lba <= 48'h0;
									remaining <= 17'h00001;
								end
								default: begin
									// Unsupported code: abort at once.
									bsy <= 1'b0;
									errb <= 1'b1;
									err_reg[atapw_pkg::ER_ABT] <= 1'b1;
									intrq_pend <= 1'b1;
									tmr_load <= 1'b0;
									state <= atapw_pkg::S_IDLE;
								end
							endcase
						end
					end
					atapw_pkg::S_WAIT: begin
						// Ask for data once the media is ready to take it.
						if (med_spun) begin
							bsy <= 1'b0;
							drq <= 1'b1;
							state <= atapw_pkg::S_XFER;
						end else if (tmr_exp) begin
							bsy <= 1'b0;
							errb <= 1'b1;
							err_reg[atapw_pkg::ER_ABT] <= 1'b1;
							intrq_pend <= 1'b1;
							state <= atapw_pkg::S_IDLE;
						end
					end
					atapw_pkg::S_XFER: begin
						if (data_wr) begin
							widx <= widx + 8'h01;
							if (widx == atapw_pkg::LAST_WORD) begin
								bsy <= 1'b1;
								drq <= 1'b0;
								med_req <= 1'b1;
								med_cmd.lba <= cur_lba;
								tmr_load <= 1'b1;
								tmr_val <= MED_TO;
								state <= atapw_pkg::S_MEDIA;
							end
						end
					end
					atapw_pkg::S_MEDIA: begin
						if ((med_done && med_err) || tmr_exp) begin
							// Stop here and report the failing sector.
							bsy <= 1'b0;
							errb <= 1'b1;
							err_reg[atapw_pkg::ER_ABT] <= 1'b1;
							intrq_pend <= 1'b1;
							rep_en <= 1'b1;
							rep_lba <= cur_lba;
							rep_cnt <= remaining;
							state <= atapw_pkg::S_IDLE;
						end else if (med_done) begin
							remaining <= remaining - 17'h00001;
							cur_lba <= cur_lba + 48'h1;
							bsy <= 1'b0;
							intrq_pend <= 1'b1;
							widx <= 8'h00;
							if (remaining == 17'h00001) begin
								rdy <= 1'b1;
								rep_en <= 1'b1;
								rep_lba <= cur_lba;
								rep_cnt <= 17'h00000;
								state <= atapw_pkg::S_IDLE;
							end else begin
								drq <= 1'b1;
								state <= atapw_pkg::S_XFER;
							end
						end
					end
					default: state <= atapw_pkg::S_RESET;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path and interrupt line.

	// Status byte: busy, ready, seek complete, data request, error.
	assign status = {bsy, rdy, 1'b0, rdy, drq, 2'b00, errb};

	// Register the read data while the host holds a read strobe.
	// Data register reads return zero, as this block
	// has no data-in phase.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hst_dd_out <= 16'h0000;
			hst_dd_oe <= 1'b0;
		end else begin
			hst_dd_oe <= ~rd_s & (cmd_sel | ctl_sel) &
				(dev[atapw_pkg::DV_SEL] == DEV_SEL);
			if (ctl_sel) begin
				hst_dd_out <= {8'h00, status};
			end else begin
				case (addr_s)
					atapw_pkg::A_DATA: hst_dd_out <= 16'h0000;
					atapw_pkg::A_FEAT: hst_dd_out <= {8'h00, err_reg};
					atapw_pkg::A_COUNT: hst_dd_out <= {8'h00, hob ? cnt[15:8] : cnt[7:0]};
					atapw_pkg::A_LOW: hst_dd_out <= {8'h00, hob ? low[15:8] : low[7:0]};
					atapw_pkg::A_MID: hst_dd_out <= {8'h00, hob ? mid[15:8] : mid[7:0]};
					atapw_pkg::A_HIGH: hst_dd_out <= {8'h00, hob ? high[15:8] : high[7:0]};
					atapw_pkg::A_DEV: hst_dd_out <= {8'h00, dev};
					default: hst_dd_out <= {8'h00, status};
				endcase
			end
		end
	end

	// Interrupt is held until the status register is read.
	assign hst_intrq = intrq_pend & ~nien;

	////////////////////////////////////////////////////////////////////////
	// Submodules.

	// Timer for reset recovery, data request and media limits.
	atapw_timer #(.W(32)) u_timer (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_exp)
	);

	// One-sector buffer between host words and the media engine.
	atapw_buf #(.W(16), .A(8)) u_buf (
		.core_clk(core_clk),
		.we(data_wr),
		.waddr(widx),
		.wdata(dd_s),
		.raddr(med_raddr),
		.rdata(med_rdata)
	);
endmodule
`default_nettype wire

// [src/atapw_pkg.sv]
/*
 * Constants, register map, command codes and carrier types for the
 * ATA PIO sector-write command block.
 * Assumes a 100 MHz core clock.
 */
`default_nettype none
package atapw_pkg;
	// Clock.
	localparam int CLK_NS = 10;
	// Time limits in their own units, and derived cycle counts (round down).
	localparam int T_DRQ_US = 700;
	localparam logic [31:0] DRQ_TO_CYC = 32'(T_DRQ_US * 1000 / CLK_NS);
	localparam longint T_SEC_S = 10;
	localparam logic [31:0] SEC_TO_CYC = 32'(T_SEC_S * 64'd1000000000 / CLK_NS);
	localparam longint T_INT_S = 30;
	localparam logic [31:0] MED_TO_CYC = 32'(T_INT_S * 64'd1000000000 / CLK_NS);
	localparam logic [31:0] RDY_CYC = 32'h0000_0040;
	// Task-file addresses (command block on cs0, control block on cs1).
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_FEAT = 3'h1;
	localparam logic [2:0] A_COUNT = 3'h2;
	localparam logic [2:0] A_LOW = 3'h3;
	localparam logic [2:0] A_MID = 3'h4;
	localparam logic [2:0] A_HIGH = 3'h5;
	localparam logic [2:0] A_DEV = 3'h6;
	localparam logic [2:0] A_CMD = 3'h7;
	localparam logic [2:0] A_DEVCTL = 3'h6;
	// Field positions of error_report, device and control.
	localparam int ER_ABT = 2;
	localparam int DV_SEL = 4;
	localparam int DC_HOB = 7;
	localparam int DC_SRST = 2;
	localparam int DC_NIEN = 1;
	// Command codes.
	localparam logic [7:0] C_WR28 = 8'h30;
	localparam logic [7:0] C_WREXT = 8'h34;
	localparam logic [7:0] C_WVFY = 8'h3C;
	localparam logic [7:0] C_SSETPW = 8'hF1;
	localparam logic [7:0] C_SUNLK = 8'hF2;
	localparam logic [7:0] C_SERASE = 8'hF4;
	localparam logic [7:0] C_SDISPW = 8'hF6;
	// Transfer sizes.
	localparam logic [7:0] LAST_WORD = 8'hFF;
	localparam logic [16:0] CNT28_ZERO = 17'h00100;
	localparam logic [16:0] CNTEXT_ZERO = 17'h10000;
	// Command kinds.
	typedef enum logic [1:0] {
		K_NONE = 2'h0, K_W28 = 2'h1, K_WEXT = 2'h2, K_SEC = 2'h3
	} atapw_kind_t;
	// Engine states, Gray coded along idle, wait, transfer, media.
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_WAIT = 3'h1, S_XFER = 3'h3, S_MEDIA = 3'h2,
		S_RESET = 3'h6
	} atapw_state_t;
	// One sector job handed to the media side.
	typedef struct packed {
		logic [47:0] lba;
		logic security;
		logic [7:0] code;
	} atapw_med_t;
endpackage
`default_nettype wire

// [src/atapw_timer.sv]
/*
 * Loadable down-counter that gives a one-cycle pulse when the loaded
 * number of cycles has elapsed.
 * Assumes a single clock; a load restarts the count at once.
 */
`timescale 1ns/1ns
`default_nettype none
module atapw_timer #(
	parameter int W = 32
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Control.
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// Result.
	output logic expired
);
	logic [W-1:0] cnt;
	logic run;

	// Count down while running and pulse on the last cycle.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '0;
			run <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (load) begin
				cnt <= (load_val == '0) ? W'(1) : load_val;
				run <= 1'b1;
			end else if (run) begin
				if (cnt == W'(1)) begin
					run <= 1'b0;
					expired <= 1'b1;
				end
				cnt <= cnt - W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// [src/atapw_buf.sv]
/*
 * Sector buffer: simple dual-port memory with a registered read port.
 * Assumes the writer and reader never touch one word in one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module atapw_buf #(
	parameter int W = 16,
	parameter int A = 8
) (
	// Clock.
	input wire logic core_clk,
	// Write port.
	input wire logic we,
	input wire logic [A-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// Read port.
	input wire logic [A-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [0:(1<<A)-1];

	// Store a word and register the read word.
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// [verif/atapw_core_properties.sv]
/*
 * Port-level timing checker for the PIO sector-write block.
 * Assumes binding to atapw_core and a host that never sets nIEN.
 */
`timescale 1ns/1ns
`default_nettype none
module atapw_core_properties (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic arst_n,
	// Host bus.
	input wire logic hst_cs0_n,
	input wire logic [2:0] hst_addr,
	input wire logic hst_wr_n,
	input wire logic hst_rd_n,
	input wire logic hst_dd_oe,
	input wire logic hst_intrq,
	// Media side.
	input wire logic med_req,
	input wire logic med_done,
	input wire logic med_err
);
	logic wr_q, rd_q, dwr, cwr, srd, stopped;
	logic [8:0] wcnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////
	// Strobe history at the pins.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= 1'b1;
			rd_q <= 1'b1;
		end else begin
			wr_q <= hst_wr_n;
			rd_q <= hst_rd_n;
		end
	end
	// Completed data write, command write and status read.
	assign dwr = hst_wr_n && !wr_q && !hst_cs0_n && hst_addr == 3'h0;
	assign cwr = hst_wr_n && !wr_q && !hst_cs0_n && hst_addr == 3'h7;
	assign srd = hst_rd_n && !rd_q && !hst_cs0_n && hst_addr == 3'h7;
	// Data words since the last sector hand-over.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) wcnt <= 9'h000;
		else if (med_req || cwr) wcnt <= 9'h000;
		else if (dwr) wcnt <= wcnt + 9'h001;
	end
	// Set by a failed sector until the next command.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) stopped <= 1'b0;
		else if (cwr) stopped <= 1'b0;
		else if (med_done && med_err) stopped <= 1'b1;
	end
	////////////////////////////////////////
	property p_rst_quiet;
		$rose(arst_n) |-> !hst_intrq && !med_req && !hst_dd_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("outputs active after reset");
	property p_req_pulse;
		med_req |=> !med_req;
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("long media request");
	property p_req_count;
		med_req |-> wcnt == 9'h100;
	endproperty
	a_req_count: assert property (p_req_count)
		else $error("sector not 256 words");
	property p_bsy_5us;
		dwr && wcnt == 9'h0FF |-> ##[1:500] med_req;
	endproperty
	a_bsy_5us: assert property (p_bsy_5us)
		else $error("late sector hand-over");
	property p_stop_err;
		stopped |-> !med_req;
	endproperty
	a_stop_err: assert property (p_stop_err)
		else $error("write after failed sector");
	property p_irq_done;
		med_done |-> ##[1:3] hst_intrq;
	endproperty
	a_irq_done: assert property (p_irq_done)
		else $error("no interrupt after sector");
	property p_irq_clear;
		srd |-> ##[1:6] !hst_intrq;
	endproperty
	a_irq_clear: assert property (p_irq_clear)
		else $error("interrupt not cleared");
	property p_oe_rd;
		$rose(hst_dd_oe) |-> !hst_rd_n;
	endproperty
	a_oe_rd: assert property (p_oe_rd)
		else $error("bus driven without read");
	property p_oe_off;
		hst_rd_n [*5] |-> !hst_dd_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("bus driven after read");
endmodule
bind atapw_core atapw_core_properties u_atapw_core_properties (
	.core_clk, .arst_n, .hst_cs0_n, .hst_addr, .hst_wr_n, .hst_rd_n,
	.hst_dd_oe, .hst_intrq, .med_req, .med_done, .med_err
);
`default_nettype wire

// [verif/atapw_host.sv]
/*
 * Behavioural host controller for the task-file bus.
 * Assumes the device synchronises the pins to core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module atapw_host (
	// Clock.
	input wire logic core_clk,
	// Task-file bus towards the device.
	output logic hst_reset_n,
	output logic hst_cs0_n,
	output logic hst_cs1_n,
	output logic [2:0] hst_addr,
	output logic hst_wr_n,
	output logic hst_rd_n,
	output logic [15:0] hst_dd_in,
	input wire logic [15:0] hst_dd_out
);
	// Idle bus; bus reset pin stays high.
	initial begin
		hst_reset_n = 1'b1;
		hst_cs0_n = 1'b1;
		hst_cs1_n = 1'b1;
		hst_addr = 3'h0;
		hst_wr_n = 1'b1;
		hst_rd_n = 1'b1;
		hst_dd_in = 16'h0000;
	end
	// One access: strobe low five clocks, read data taken at its last edge.
	task automatic acc(input logic cs1, input logic wr,
		input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge core_clk);
		#1;
		hst_cs0_n = cs1;
		hst_cs1_n = !cs1;
		hst_addr = a;
		hst_dd_in = d;
		hst_wr_n = !wr;
		hst_rd_n = wr;
		repeat (5) @(posedge core_clk);
		q = hst_dd_out;
		#1;
		hst_wr_n = 1'b1;
		hst_rd_n = 1'b1;
		@(posedge core_clk);
		#1;
		hst_cs0_n = 1'b1;
		hst_cs1_n = 1'b1;
		hst_dd_in = ~d;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// Soft reset: bit up, status read, bit down.
	task automatic sreset(output logic [15:0] q);
		logic [15:0] j;
		acc(1'b1, 1'b1, 3'h6, 16'h0004, j);
		acc(1'b0, 1'b0, 3'h7, 16'h0000, q);
		acc(1'b1, 1'b1, 3'h6, 16'h0000, j);
	endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
/*
 * Self-checking bench for the PIO sector-write block.
 * Assumes atapw_host as bus master and an inline media responder.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	fails++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
	typedef struct {
		logic [7:0] cmd;
		logic [15:0] cnt;
		logic [47:0] lba;
		logic [3:0] head;
		int err_at;
		int n;
		logic [7:0] st;
	} atapw_row_t;
	atapw_row_t rows [6] = '{
		'{8'h34, 16'h0002, 48'h123456789ABC, 4'h0, 0, 2, 8'h40},
		'{8'h30, 16'h0001, 48'h000000ABCDEF, 4'h5, 0, 1, 8'h40},
		'{8'h3C, 16'h0001, 48'h000000102030, 4'hA, 0, 1, 8'h40},
		'{8'h31, 16'h0001, 48'h0000000000FF, 4'h0, 0, 1, 8'h40},
		'{8'h34, 16'h0000, 48'h00FFFFFFFFFF, 4'h0, 2, 65536, 8'h41},
		'{8'h30, 16'h0000, 48'h0000000001FF, 4'h2, 2, 256, 8'h41}
	};
	logic core_clk, arst_n, hst_reset_n, hst_cs0_n, hst_cs1_n, hst_wr_n;
	logic hst_rd_n, hst_dd_oe, hst_intrq, pwr_standby, med_spun, med_req;
	logic med_done, med_err, fail_now;
	logic [2:0] hst_addr;
	logic [7:0] med_raddr;
	logic [15:0] hst_dd_in, hst_dd_out, med_rdata, q, word5;
	logic [47:0] exp_lba;
	atapw_pkg::atapw_med_t med_cmd;
	int fails = 0;
	int check_count = 0;
	////////////////////////////////////////
	// Clock at 100 MHz.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Device with short time limits and host model.
	atapw_core #(.DRQ_TO(32'h64), .SEC_TO(32'h12C), .MED_TO(32'hC8))
		u_atapw_core (.core_clk,
		.arst_n, .hst_reset_n, .hst_cs0_n, .hst_cs1_n, .hst_addr, .hst_wr_n,
		.hst_rd_n, .hst_dd_in, .hst_dd_out, .hst_dd_oe, .hst_intrq,
		.pwr_standby, .med_spun, .med_req, .med_cmd, .med_raddr, .med_rdata,
		.med_done, .med_err);
	atapw_host u_atapw_host (.core_clk, .hst_reset_n, .hst_cs0_n,
		.hst_cs1_n, .hst_addr, .hst_wr_n, .hst_rd_n, .hst_dd_in, .hst_dd_out);
	// Media responder: checks each job, then finishes it.
	initial forever begin
		@(posedge core_clk);
		#1;
		if (med_req === 1'b1) begin
			`CHK("media lba", exp_lba, med_cmd.lba)
			med_raddr = 8'h05;
			repeat (2) @(posedge core_clk);
			`CHK("buffer word", word5, med_rdata)
			repeat (8) @(posedge core_clk);
			#1;
			med_done = 1'b1;
			med_err = fail_now;
			@(posedge core_clk);
			#1;
			med_done = 1'b0;
			med_err = 1'b0;
		end
	end
	////////////////////////////////////////
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		u_atapw_host.acc(1'b0, 1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a);
		u_atapw_host.acc(1'b0, 1'b0, a, 16'h0000, q);
	endtask
	// Bounded wait for interrupt.
	task automatic wait_irq(input int lim);
		int k = 0;
		while (hst_intrq !== 1'b1 && k < lim) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		`CHK("interrupt", 1'b1, hst_intrq)
	endtask
	// Polls status, at most 30 reads.
	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		int k = 0;
		do begin
			rd(3'h7);
			k++;
		end while ((q[7:0] & m) !== v && k < 30);
		`CHK("status poll", v, q[7:0] & m)
	endtask
	// Power-on reset, then ready.
	task automatic por(input logic stby);
		@(posedge core_clk);
		#1;
		arst_n = 1'b0;
		pwr_standby = stby;
		repeat (5) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		rd(3'h7);
		`CHK("busy after reset", 1'b1, q[7])
		wait_st(8'hC0, 8'h40);
	endtask
	// Task file, previous bytes first.
	task automatic issue(input atapw_row_t r);
		if (r.cmd == 8'h34) begin
			wr(3'h2, {8'h00, r.cnt[15:8]});
			wr(3'h3, {8'h00, r.lba[31:24]});
			wr(3'h4, {8'h00, r.lba[39:32]});
			wr(3'h5, {8'h00, r.lba[47:40]});
		end
		wr(3'h2, {8'h00, r.cnt[7:0]});
		wr(3'h3, {8'h00, r.lba[7:0]});
		wr(3'h4, {8'h00, r.lba[15:8]});
		wr(3'h5, {8'h00, r.lba[23:16]});
		wr(3'h6, {12'h004, r.head});
		wr(3'h7, {8'h00, r.cmd});
	endtask
	// Whole command with read-back.
	task automatic do_row(input atapw_row_t r);
		logic [47:0] base, got;
		logic [15:0] got_cnt;
		int run;
		base = r.cmd == 8'h34 ? r.lba : {20'h00000, r.head, r.lba[23:0]};
		run = r.err_at != 0 ? r.err_at : r.n;
		issue(r);
		for (int s = 0; s < run; s++) begin
			wait_st(8'h88, 8'h08);
			exp_lba = base + 48'(s);
			word5 = {8'(s), 8'h05};
			fail_now = s + 1 == r.err_at;
			for (int i = 0; i < 256; i++) wr(3'h0, {8'(s), 8'(i)});
			wait_irq(400);
		end
		rd(3'h7);
		`CHK("final status", r.st, q[7:0] & 8'hC9)
		got = base + 48'(run - 1);
		got_cnt = 16'(r.n - run + (r.err_at != 0));
		for (int h = 0; h < (r.cmd == 8'h34 ? 2 : 1); h++) begin
			u_atapw_host.acc(1'b1, 1'b1, 3'h6, {8'h00, 1'(h), 7'h00}, q);
			rd(3'h2);
			got_cnt[8*h +: 8] = q[7:0];
			for (int b = 0; b < 3; b++) begin
				rd(3'(3 + b));
				got[24*h + 8*b +: 8] = q[7:0];
			end
		end
		u_atapw_host.acc(1'b1, 1'b1, 3'h6, 16'h0000, q);
		`CHK("count left", 16'(r.n - run + (r.err_at != 0)), got_cnt)
		`CHK("last address", base + 48'(run - 1), got)
	endtask
	// Final verdict and end of run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// Watchdog, well past the run length.
	initial begin
		repeat (80000) @(posedge core_clk);
		fails++;
		test_done();
	end
	// Table rows, then timeouts and resets.
	initial begin
		arst_n = 1'b0;
		pwr_standby = 1'b0;
		med_spun = 1'b1;
		med_done = 1'b0;
		med_err = 1'b0;
		med_raddr = 8'h00;
		fail_now = 1'b0;
		exp_lba = 48'h000000000000;
		word5 = 16'h0000;
		por(1'b0);
		for (int r = 0; r < 6; r++) begin
			do_row(rows[r]);
			$display("test row %0d done", r);
		end
		med_spun = 1'b0;
		issue(rows[2]);
		wait_irq(200);
		rd(3'h1);
		`CHK("abort bit", 1'b1, q[2])
		u_atapw_host.sreset(q);
		`CHK("busy in soft reset", 1'b1, q[7])
		wait_st(8'hC0, 8'h40);
		med_spun = 1'b1;
		do_row(rows[2]);
		$display("test data request timeout done");
		por(1'b1);
		med_spun = 1'b0;
		wr(3'h7, 16'h00F1);
		repeat (150) @(posedge core_clk);
		rd(3'h7);
		`CHK("still waiting", 8'hC0, q[7:0] & 8'hC9)
		wait_irq(300);
		rd(3'h7);
		`CHK("late abort", 8'h41, q[7:0] & 8'hC9)
		$display("test standby security done");
		test_done();
	end
endmodule
`default_nettype wire
